// ===== design/io_base_status.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module io_base_status
    import io_base_pkg::*;
#(
    parameter int          TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS,
    parameter int          FLASH_HALF_CYCLES = CLK_HZ / (2 * FLASH_HZ),
    parameter logic [15:0] BASE_TYPE         = 16'h00a5,  // Arbitrary value
    parameter logic [127:0] FW_VERSION       = 128'h0001_0002_0003_0004_0005_0006_0007_0008  // Arbitrary value
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic [7:0]        module_config_mismatch,
    input  wire logic [7:0]        module_error,
    input  wire logic [7:0]        module_calibration,
    input  wire logic              watchdog_trip,
    input  wire logic              powerup_fault,
    input  wire logic              base_offline,
    input  wire logic [15:0]       input1_mv,
    input  wire logic [15:0]       input2_mv,
    input  wire logic [2:0]        alarm_level,
    input  wire logic              lifetime_event,
    input  wire logic [15:0]       base_network_id,
    input  wire logic [15:0]       base_scan_rate,
    input  wire logic              host_stop,
    input  wire logic              comm_timeout,
    input  wire logic [15:0]       ai_value,
    input  wire logic              ai_open_circuit,
    input  wire logic [15:0]       ao_host_value,
    output logic                   ai_sample,
    output logic [15:0]            ao_value,
    output logic                   power_led,
    output logic                   ok_led,
    output logic                   module_led,
    output logic                   network_led,
    output logic                   analog_in_led,
    output logic                   analog_out_led
);

    // Refuse counts the dividers cannot serve
    if (TICK_CYCLES < 1 || FLASH_HALF_CYCLES < 1) begin : g_bad_count
        $error("io_base_status: divider counts must be at least one");
    end

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        configured;
        logic        ai_en;
        logic        ao_en;
        logic [1:0]  ai_mode;
        logic [1:0]  ao_stop;
        logic [14:0] period;
        logic [31:0] tick_cnt;
        logic [14:0] period_cnt;
        logic        ai_sample;
        logic [31:0] flash_cnt;
        logic        flash;
        logic        powerup_error;
        logic        life;
        logic [15:0] wdg_cnt;
        logic [1:0]  undef;
        logic [15:0] ao_value;
        led_mode_e   led_mode;
        logic        power_led;
        logic        ok_led;
        logic        module_led;
        logic        network_led;
        logic        ai_led;
        logic        ao_led;
    } state_s;

    state_s s_q;
    state_s s_d;

    // True while a 24V input sits in the undefined band
    function automatic logic in_band(input logic [15:0] mv);
        in_band = (mv >= UNDEF_LO_MV) && (mv <= UNDEF_HI_MV);
    endfunction : in_band

    // Alarm level to extreme, b1, b0
    function automatic logic [2:0] alarm_bits(input logic [2:0] lvl);
        case (lvl)
            ALARM_LOW:       alarm_bits = 3'h1;
            ALARM_HIGH:      alarm_bits = 3'h2;
            ALARM_LOW_LOW:   alarm_bits = 3'h4;
            ALARM_HIGH_HIGH: alarm_bits = 3'h7;
            default:         alarm_bits = 3'h0;
        endcase
    endfunction : alarm_bits

    logic        access;
    logic        wr;
    logic [15:0] word3;
    logic [3:0]  widx;

    // Decode of the APB access phase
    assign access = psel && penable && !s_q.pready;
    assign wr     = access && pwrite;
    assign widx   = 4'(paddr[ADDR_W-1:2]);

    // Status word 3 assembly
    always_comb begin
        word3                     = 16'h0000;
        word3[W3_PUP]             = s_q.powerup_error;
        word3[W3_OFFLINE]         = base_offline;
        word3[W3_IN1]             = s_q.undef[0];
        word3[W3_IN2]             = s_q.undef[1];
        word3[W3_ALARM_EXTREME:W3_ALM0]    = {alarm_bits(alarm_level)};
        word3[W3_LIFE]            = s_q.life;
        word3[W3_NOCFG]           = !s_q.configured;
    end

    // Next state of the whole block
    always_comb begin
        s_d           = s_q;
        s_d.pready    = access;
        s_d.pslverr   = 1'b0;
        s_d.ai_sample = 1'b0;

        // Register reads, latched with the answer
        if (access && !pwrite) begin
            s_d.prdata = 32'h0000_0000;
            if (paddr[1:0] != 2'h0) begin
                s_d.pslverr = 1'b1;
            end else if (paddr == CTRL_OFF) begin
                s_d.prdata = {25'h0, s_q.ao_stop, s_q.ai_mode, s_q.ao_en, s_q.ai_en, s_q.configured};
            end else if (paddr == PERIOD_OFF) begin
                s_d.prdata = {17'h0, s_q.period};
            end else if (paddr >= STATUS_BASE && int'(paddr[ADDR_W-1:2]) < STATUS_WORDS) begin  // Whole index, no alias
                case (widx)
                    4'h0: s_d.prdata = {16'h0, module_error, module_config_mismatch};
                    4'h1: s_d.prdata = {16'h0, module_calibration, s_q.wdg_cnt[7:0]};
                    4'h2: s_d.prdata = {16'h0, word3};
                    4'h3: s_d.prdata = {16'h0, base_network_id};
                    4'h4: s_d.prdata = {16'h0, BASE_TYPE};
                    4'h5: s_d.prdata = {16'h0, base_scan_rate};
                    4'h6: s_d.prdata = {16'h0, s_q.wdg_cnt};
                    default: s_d.prdata = {16'h0, FW_VERSION[16*(14-int'(widx)) +: 16]};
                endcase
            end else begin
                s_d.pslverr = 1'b1;
            end
        end

        // Register writes
        if (wr) begin
            if (paddr == CTRL_OFF) begin
                s_d.configured = pwdata[CT_CONFIGURED];
                s_d.ai_en      = pwdata[CT_AI_EN];
                s_d.ao_en      = pwdata[CT_AO_EN];
                s_d.ai_mode    = pwdata[CT_AI_MODE +: 2];
                s_d.ao_stop    = pwdata[CT_AO_STOP +: 2];
            end else if (paddr == PERIOD_OFF) begin
                // Out-of-range periods are refused
                if (pwdata[14:0] >= PERIOD_MIN && pwdata[14:0] <= PERIOD_MAX && pwdata[31:15] == 17'h0) begin
                    s_d.period = pwdata[14:0];
                end else begin
                    s_d.pslverr = 1'b1;
                end
            end else if (paddr == WORD3_OFF) begin
                if (pwdata[W3_LIFE]) begin
                    s_d.life = 1'b0;
                end
            end else begin
                s_d.pslverr = 1'b1;
            end
        end

        // Sticky flags, set wins over clear
        if (powerup_fault) begin
            s_d.powerup_error = 1'b1;
        end
        if (lifetime_event) begin
            s_d.life = 1'b1;
        end

        // Watchdog trip count, saturating
        if (watchdog_trip && s_q.wdg_cnt != CNT_MAX) begin
            s_d.wdg_cnt = s_q.wdg_cnt + 16'h0001;
        end

        s_d.undef = {in_band(input2_mv), in_band(input1_mv)};

        // 10 ms tick and analog update period
        if (s_q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = 32'h0000_0000;
            if (s_q.period_cnt >= s_q.period - 15'h0001) begin
                s_d.period_cnt = 15'h0000;
                s_d.ai_sample  = s_q.ai_en;
            end else begin
                s_d.period_cnt = s_q.period_cnt + 15'h0001;
            end
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
        end

        // Shared 1 Hz flash divider
        if (s_q.flash_cnt == 32'(FLASH_HALF_CYCLES - 1)) begin
            s_d.flash_cnt = 32'h0000_0000;
            s_d.flash     = !s_q.flash;
        end else begin
            s_d.flash_cnt = s_q.flash_cnt + 32'h0000_0001;
        end

        // Indicator mode, mismatch first
        if (|module_config_mismatch) begin
            s_d.led_mode = LED_MISMATCH;
        end else if (!s_q.configured) begin
            s_d.led_mode = LED_UNCONFIGURED;
        end else if (host_stop || comm_timeout) begin
            s_d.led_mode = LED_STOPPED;
        end else begin
            s_d.led_mode = LED_NORMAL;
        end

        // Base LEDs
        s_d.power_led = 1'b1;
        case (s_q.led_mode)
            LED_MISMATCH: begin
                s_d.ok_led      = s_q.flash;
                s_d.module_led  = 1'b1;
                s_d.network_led = s_q.flash;
            end
            LED_UNCONFIGURED: begin
                s_d.ok_led      = 1'b1;
                s_d.module_led  = s_q.flash;
                s_d.network_led = s_q.flash;
            end
            LED_STOPPED: begin
                s_d.ok_led      = 1'b1;
                s_d.module_led  = 1'b1;
                s_d.network_led = s_q.flash;
            end
            default: begin
                s_d.ok_led      = 1'b1;
                s_d.module_led  = 1'b1;
                s_d.network_led = !base_offline;
            end
        endcase

        // Analog input channel LED
        if (!s_q.ai_en) begin
            s_d.ai_led = 1'b0;
        end else begin
            case (s_q.ai_mode)
                AI_MODE_LINEAR: s_d.ai_led = ai_value > AI_THRESH;
                AI_MODE_RTD:    s_d.ai_led = !ai_open_circuit;
                AI_MODE_TC:     s_d.ai_led = 1'b1;
                default:        s_d.ai_led = 1'b1;
            endcase
        end
        s_d.ao_led = s_q.ao_en;

        // Analog output value, stop/idle behaviour
        if (!(host_stop || comm_timeout)) begin
            s_d.ao_value = ao_host_value;
        end else begin
            case (s_q.ao_stop)
                AO_STOP_HOLD: s_d.ao_value = s_q.ao_value;
                AO_STOP_MID:  s_d.ao_value = AO_MID;
                AO_STOP_MAX:  s_d.ao_value = AI_FULL;
                default:      s_d.ao_value = AO_ZERO;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q        <= '0;
            s_q.period <= PERIOD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign pready         = s_q.pready;
    assign pslverr        = s_q.pslverr;
    assign prdata         = s_q.prdata;
    assign ai_sample      = s_q.ai_sample;
    assign ao_value       = s_q.ao_value;
    assign power_led      = s_q.power_led;
    assign ok_led         = s_q.ok_led;
    assign module_led     = s_q.module_led;
    assign network_led    = s_q.network_led;
    assign analog_in_led  = s_q.ai_led;
    assign analog_out_led = s_q.ao_led;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence apb_setup;
        psel && !penable;
    endsequence

    sequence apb_access;
        psel && penable;
    endsequence

    // Bus answer one cycle after access phase starts
    apb_answer_a: assert property (apb_setup ##1 apb_access |=> pready)
        else $error("APB answer missing");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");

    pup_sticky_a: assert property (s_q.powerup_error |=> s_q.powerup_error)
        else $error("power-up flag dropped");
    life_hold_a: assert property (s_q.life && !(wr && paddr == WORD3_OFF && pwdata[W3_LIFE]) |=> s_q.life)
        else $error("lifetime flag lost");
    wdg_count_a: assert property (watchdog_trip && s_q.wdg_cnt != CNT_MAX |=> s_q.wdg_cnt == $past(s_q.wdg_cnt) + 16'h0001)
        else $error("watchdog count did not advance");
    undef_band_a: assert property (s_q.undef[0] == $past(in_band(input1_mv)))
        else $error("undefined flag wrong");
    mismatch_led_a: assert property (s_q.led_mode == LED_MISMATCH |=> module_led && ok_led == $past(s_q.flash))
        else $error("mismatch LEDs wrong");
    stop_led_a: assert property (s_q.led_mode == LED_STOPPED |=> ok_led && network_led == $past(s_q.flash))
        else $error("stop LEDs wrong");
    flash_step_a: assert property ($changed(s_q.flash) |-> $past(s_q.flash_cnt) == 32'(FLASH_HALF_CYCLES - 1))
        else $error("flash toggled off schedule");
    ai_off_a: assert property (!s_q.ai_en |=> !analog_in_led)
        else $error("disabled channel LED lit");
    ao_min_a: assert property (host_stop && s_q.ao_stop == AO_STOP_MIN |=> ao_value == AO_ZERO)
        else $error("stop output not minimum");

    // Sticky flags follow their events one edge later
    pup_set_a: assert property (powerup_fault |=> s_q.powerup_error)
        else $error("power-up flag not set");
    life_set_a: assert property (lifetime_event |=> s_q.life)
        else $error("lifetime flag not set");

    // Refused period keeps the old setting
    period_keep_a: assert property (wr && paddr == PERIOD_OFF && (pwdata[14:0] < PERIOD_MIN || pwdata[14:0] > PERIOD_MAX)
        |=> $stable(s_q.period) && pslverr)
        else $error("refused period taken");

    // Base LED modes
    unconf_led_a: assert property (s_q.led_mode == LED_UNCONFIGURED
        |=> ok_led && module_led == $past(s_q.flash) && network_led == $past(s_q.flash))
        else $error("unconfigured LEDs wrong");
    mode_prio_a: assert property (module_config_mismatch != 8'h00 |=> s_q.led_mode == LED_MISMATCH)
        else $error("mismatch not shown first");
    stop_module_a: assert property (s_q.led_mode == LED_STOPPED |=> module_led && power_led)
        else $error("stop module LED off");

    // Channel LEDs
    lin_led_a: assert property (s_q.ai_en && s_q.ai_mode == AI_MODE_LINEAR
        |=> analog_in_led == ($past(ai_value) > AI_THRESH))
        else $error("linear channel LED wrong");
    rtd_led_a: assert property (s_q.ai_en && s_q.ai_mode == AI_MODE_RTD
        |=> analog_in_led == !$past(ai_open_circuit))
        else $error("RTD channel LED wrong");
    tc_led_a: assert property (s_q.ai_en && s_q.ai_mode == AI_MODE_TC |=> analog_in_led)
        else $error("thermocouple LED off");
    out_led_a: assert property (!s_q.ao_en |=> !analog_out_led)
        else $error("disabled output LED lit");

    // Output hold and sample gating
    ao_hold_a: assert property ((host_stop || comm_timeout) && s_q.ao_stop == AO_STOP_HOLD
        |=> $stable(ao_value))
        else $error("held output moved");
    sample_gate_a: assert property (ai_sample |-> $past(s_q.ai_en))
        else $error("sample while disabled");

endmodule : io_base_status

// ===== shared/io_base_pkg.sv
// Contract
// - Word 1 low byte: per-module config mismatch
// - Word 1 high byte: per-module error
// - Word 2 high byte: per-module calibration
// - Word 2 low byte: watchdog trip count
// - Word 7: full 16-bit watchdog trip count
// - Power-up error flag stays set, sticky
// - Offline flag high while base offline
// - Undefined flag high inside 8V-16V band
// - Alarm bits encode normal/low/high/low-low/high-high
// - Lifetime error held until host clears it
// - Word 3 reports not-configured flag
// - Words 8 to 15 hold firmware version
// - Stop or timeout: network LED flashes
// - Unconfigured: module and network LEDs flash
// - Mismatch: ok and network flash, module on
// - Disabled channel keeps its LED off
// - Current/voltage input LED off below 0.2%
// - RTD input LED off on open circuit
// - Thermocouple input LED on when enabled
// - Analog update period 10 ms to 255 s
// - Stop/idle output: hold, min, mid, max
package io_base_pkg;
    // Timing
    localparam int CLK_HZ   = 125_000_000;
    localparam int TICK_MS  = 10;
    localparam int FLASH_HZ = 1;
    // Update period in 10 ms ticks
    localparam logic [14:0] PERIOD_MIN = 15'h0001;
    localparam logic [14:0] PERIOD_MAX = 15'h639c;
    localparam logic [14:0] PERIOD_RST = 15'h0064;
    // Undefined band of a 24V input, millivolts
    localparam logic [15:0] UNDEF_LO_MV = 16'h1f40;
    localparam logic [15:0] UNDEF_HI_MV = 16'h3e80;
    // Analog input zero threshold, 0.2 percent of full scale
    localparam int          AI_PERMILLE = 2;
    localparam logic [15:0] AI_FULL     = 16'hffff;
    localparam logic [15:0] AI_THRESH   = 16'((65535 * AI_PERMILLE) / 1000);
    localparam logic [15:0] AO_MID      = 16'h8000;
    localparam logic [15:0] AO_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    // Register map, byte addresses
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  STATUS_BASE = 8'h00;
    localparam int          STATUS_WORDS = 15;
    localparam logic [7:0]  CTRL_OFF    = 8'h40;
    localparam logic [7:0]  PERIOD_OFF  = 8'h44;
    localparam logic [7:0]  WORD3_OFF   = 8'h08;
    // Status word 3 bit positions
    localparam int W3_PUP = 0;
    localparam int W3_OFFLINE = 1;
    localparam int W3_IN1 = 2;
    localparam int W3_IN2 = 3;
    localparam int W3_ALM0 = 4;
    localparam int W3_ALARM_B1 = 5;
    localparam int W3_ALARM_EXTREME = 6;
    localparam int W3_LIFE = 7;
    localparam int W3_NOCFG = 8;
    // Control register bit positions
    localparam int CT_CONFIGURED = 0;
    localparam int CT_AI_EN = 1;
    localparam int CT_AO_EN = 2;
    localparam int CT_AI_MODE = 3;
    localparam int CT_AO_STOP = 5;
    // Analog input modes
    localparam logic [1:0] AI_MODE_LINEAR = 2'h0;
    localparam logic [1:0] AI_MODE_RTD    = 2'h1;
    localparam logic [1:0] AI_MODE_TC     = 2'h2;
    // Analog output stop/idle behaviour
    localparam logic [1:0] AO_STOP_MIN  = 2'h0;
    localparam logic [1:0] AO_STOP_HOLD = 2'h1;
    localparam logic [1:0] AO_STOP_MID  = 2'h2;
    localparam logic [1:0] AO_STOP_MAX  = 2'h3;
    typedef enum logic [2:0] {ALARM_NORMAL, ALARM_LOW, ALARM_HIGH, ALARM_LOW_LOW, ALARM_HIGH_HIGH} alarm_level_e;
    typedef enum logic [1:0] {LED_NORMAL, LED_MISMATCH, LED_UNCONFIGURED, LED_STOPPED} led_mode_e;
endpackage : io_base_pkg

// ===== tb/host_master.sv
`timescale 1ns/10ps
module host_master
    import io_base_pkg::*;
(
    input  wire logic              core_clk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire logic [31:0]       prdata
);
    // Bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // One transfer; the host clears the lifetime flag by writing a one to it
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines stop showing the old request
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : host_master

// ===== tb/io_base_status_and_indicators_bench.sv
`timescale 1ns/10ps
module io_base_status_and_indicators_bench
    import io_base_pkg::*;
;
    localparam int             TK = 4;
    localparam logic [15:0]    BT = 16'h5a3c;  // Arbitrary value
    localparam logic [127:0]   FW = 128'h1111_2222_3333_4444_5555_6666_7777_8888;  // Arbitrary value
    typedef struct {logic e; logic [31:0] d; logic [31:0] m;} note_s;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, ai_sample;
    logic [7:0]  paddr, module_config_mismatch, module_error, module_calibration;
    logic [31:0] pwdata, prdata, r;
    logic watchdog_trip, powerup_fault, base_offline, lifetime_event, host_stop, comm_timeout, ai_open_circuit;
    logic [15:0] input1_mv, input2_mv, base_network_id, base_scan_rate, ai_value, ao_host_value, ao_value;
    alarm_level_e alarm_level;
    logic power_led, ok_led, module_led, network_led, analog_in_led, analog_out_led;
    note_s exp_q[$];
    note_s cur;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    logic [2:0]  acode [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    logic [15:0] aexp [4];

    io_base_status #(.TICK_CYCLES(TK), .FLASH_HALF_CYCLES(8), .BASE_TYPE(BT), .FW_VERSION(FW)) u_io_base_status (
        .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .module_config_mismatch, .module_error, .module_calibration, .watchdog_trip, .powerup_fault,
        .base_offline, .input1_mv, .input2_mv, .alarm_level, .lifetime_event, .base_network_id,
        .base_scan_rate, .host_stop, .comm_timeout, .ai_value, .ai_open_circuit, .ao_host_value,
        .ai_sample, .ao_value, .power_led, .ok_led, .module_led, .network_led, .analog_in_led,
        .analog_out_led);
    host_master u_host_master (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic bad(input string s);
        miscompares++;
        $display("[ERR] %0t %s", $time, s);
    endtask : bad

    task automatic complete_run;
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    // Register accesses note their expected answer first
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1, input logic e = 1'b0);
        exp_q.push_back('{e, d, m});
        u_host_master.xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
        exp_q.push_back('{e, 32'h0, 32'h0});
        u_host_master.xfer(1'b1, a, d);
    endtask : wr

    // Every answer is compared with the oldest note
    always @(posedge core_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0) begin
                bad("unexpected answer");
            end else begin
                cur = exp_q.pop_front();
                if (pslverr !== cur.e || (prdata & cur.m) !== (cur.d & cur.m)) bad("bus answer");
            end
        end
    end

    // Steady LEDs against on, flashing LEDs invert in phase over a half period
    task automatic leds(input logic [3:0] on, input logic [3:0] fl);
        logic [3:0] a;
        logic [3:0] b;
        repeat (4) @(negedge core_clk);
        a = {power_led, ok_led, module_led, network_led};
        repeat (8) @(negedge core_clk);
        b = {power_led, ok_led, module_led, network_led};
        check_count++;
        if ((a & ~fl) !== on || (b & ~fl) !== on || (b & fl) !== (~a & fl) || ((a & fl) !== 4'h0 && (a & fl) !== fl))
            bad("led pattern");
        @(posedge core_clk);
    endtask : leds

    task automatic ai_case(input logic [6:0] c, input logic [15:0] v, input logic o, input logic e);
        ai_value        <= v;
        ai_open_circuit <= o;
        wr(8'h40, {25'h0, c});
        repeat (3) @(negedge core_clk);
        check_count++;
        if (analog_in_led !== e || analog_out_led !== c[2]) bad("channel led");
        @(posedge core_clk);
    endtask : ai_case

    // Cycles between two later sample pulses
    task automatic period(input logic [14:0] p);
        int n;
        wr(8'h44, {17'h0, p});
        repeat (3) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (ai_sample !== 1'b1 && n < 500);
        end
        check_count++;
        if (n !== int'(p) * TK) bad("sample period");
        @(posedge core_clk);
    endtask : period

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad("timeout");
            complete_run();
        end
    end

    initial begin
        nrst = 1'b0;
        {module_config_mismatch, module_error, module_calibration, watchdog_trip, powerup_fault} = '0;
        {base_offline, input1_mv, input2_mv, lifetime_event, base_network_id, base_scan_rate} = '0;
        {host_stop, comm_timeout, ai_value, ai_open_circuit, ao_host_value} = '0;
        alarm_level = ALARM_NORMAL;
        r = 32'h2cedcc44;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h08, 32'h100);
        rd(8'h44, {17'h0, PERIOD_RST});
        leds(4'b1100, 4'b0011);
        r = lfsr(r);
        module_config_mismatch <= r[7:0] | 8'h01;
        module_error <= r[15:8];
        module_calibration <= r[23:16];
        base_network_id <= r[15:0];
        base_scan_rate <= r[31:16];
        watchdog_trip <= 1'b1;
        repeat (3) @(posedge core_clk);
        watchdog_trip <= 1'b0;
        rd(8'h00, {r[15:8], r[7:0] | 8'h01});
        rd(8'h04, {r[23:16], 8'h03});
        rd(8'h18, 32'h3);
        rd(8'h0c, r[15:0]);
        rd(8'h10, BT);
        rd(8'h14, r[31:16]);
        for (int i = 0; i < 8; i++) rd(8'(8'h1c + 4 * i), FW[127 - 16 * i -: 16]);
        wr(8'h00, 32'h0, 1'b1);
        wr(8'h48, 32'h0, 1'b1);
        rd(8'h01, 32'h0, 32'h0, 1'b1);
        rd(8'h48, 32'h0, 32'h0, 1'b1);
        leds(4'b1010, 4'b0101);
        powerup_fault <= 1'b1;
        base_offline <= 1'b1;
        input1_mv <= UNDEF_LO_MV;
        input2_mv <= UNDEF_HI_MV + 16'h1;
        @(posedge core_clk);
        powerup_fault <= 1'b0;
        rd(8'h08, 32'h107);
        base_offline <= 1'b0;
        input1_mv <= UNDEF_LO_MV - 16'h1;
        input2_mv <= UNDEF_HI_MV;
        rd(8'h08, 32'h109);
        for (int i = 0; i < 5; i++) begin
            alarm_level <= alarm_level_e'(i);
            rd(8'h08, {25'h0, acode[i], 4'h0}, 32'h70);
        end
        lifetime_event <= 1'b1;
        @(posedge core_clk);
        lifetime_event <= 1'b0;
        rd(8'h08, 32'h80, 32'h80);
        rd(8'h08, 32'h80, 32'h80);
        wr(8'h08, 32'h80);
        rd(8'h08, 32'h0, 32'h80);
        module_config_mismatch <= 8'h0;
        wr(8'h40, 32'h1);
        rd(8'h08, 32'h0, 32'h100);
        leds(4'b1111, 4'b0000);
        host_stop <= 1'b1;
        leds(4'b1110, 4'b0001);
        host_stop <= 1'b0;
        comm_timeout <= 1'b1;
        leds(4'b1110, 4'b0001);
        comm_timeout <= 1'b0;
        ai_case(7'h11, 16'hffff, 1'b0, 1'b0);
        ai_case(7'h03, AI_THRESH, 1'b0, 1'b0);
        ai_case(7'h03, AI_THRESH + 16'h1, 1'b0, 1'b1);
        ai_case(7'h0f, 16'h0, 1'b1, 1'b0);
        ai_case(7'h0b, 16'h0, 1'b0, 1'b1);
        ai_case(7'h13, 16'h0, 1'b0, 1'b1);
        aexp = '{AO_ZERO, r[15:0], AO_MID, AI_FULL};
        for (int i = 0; i < 4; i++) begin
            host_stop <= 1'b0;
            ao_host_value <= r[15:0];
            wr(8'h40, 32'h5 | (i << 5));
            @(negedge core_clk);
            check_count++;
            if (ao_value !== r[15:0]) bad("output value");
            host_stop <= 1'b1;
            repeat (2) @(posedge core_clk);
            ao_host_value <= ~r[15:0];
            repeat (3) @(negedge core_clk);
            check_count++;
            if (ao_value !== aexp[i]) bad("stop value");
            @(posedge core_clk);
        end
        host_stop <= 1'b0;
        wr(8'h44, 32'h0, 1'b1);
        wr(8'h44, 32'd25501, 1'b1);
        wr(8'h44, 32'h8001, 1'b1);
        wr(8'h44, {17'h0, PERIOD_MAX});
        rd(8'h44, {17'h0, PERIOD_MAX});
        wr(8'h40, 32'h3);
        period(PERIOD_MIN);
        period(15'h3);
        repeat (3) @(posedge core_clk);
        complete_run();
    end
endmodule : io_base_status_and_indicators_bench
